// File: qdsu_regs.svh
// qdsu_regs.svh: frame layout, encodings and timing constants of the quad converter link
// assumes: included by the package user files; definitions only
`ifndef QDSU_REGS_SVH
`define QDSU_REGS_SVH
`define QDSU_FRAME_BITS      24
`define QDSU_ADDR_HI_POS     23
`define QDSU_ADDR_LO_POS     22
`define QDSU_LOAD_ALL_POS    21
`define QDSU_LOAD_SEL_POS    20
`define QDSU_UNUSED_POS      19
`define QDSU_CHAN_HI_POS     18
`define QDSU_CHAN_LO_POS     17
`define QDSU_PD_FLAG_POS     16
`define QDSU_PD_MODE_HI_POS  15
`define QDSU_PD_MODE_LO_POS  14
`define QDSU_ZERO_SCALE      16'h0000
`define QDSU_MID_SCALE       16'h8000
`define QDSU_PD_NONE         2'h0
`define QDSU_PD_1K           2'h1
`define QDSU_PD_100K         2'h2
`define QDSU_PD_HIZ          2'h3
`define QDSU_SCLK_HALF_DIV   4
`endif

// File: qdsu_pkg.sv
// qdsu_pkg.sv: types shared by both ends of the quad converter serial link
// assumes: compiled before the interface and the end modules
package qdsu_pkg;
  // one holding buffer or output register: power-down state plus code
  typedef struct packed {
    logic [1:0]  pd_mode;
    logic [15:0] code;
  } qdsu_chan_type;
endpackage

// File: qdsu_link_if.sv
// qdsu_link_if.sv: three-wire serial link plus update strobe and port disable between host and converter
// assumes: host drives frame select, serial clock and data; device only listens
`timescale 1ns/100ps
interface qdsu_link_if;
  logic sync_n;
  logic sclk;
  logic sdata;
  logic update_strobe;
  logic port_disable;
  modport host_mp (
    output sync_n,
    output sclk,
    output sdata,
    output update_strobe,
    output port_disable
  );
  modport dev_mp (
    input sync_n,
    input sclk,
    input sdata,
    input update_strobe,
    input port_disable
  );
endinterface

// File: qdsu_device.sv
// qdsu_device.sv: converter end; frame decode, holding buffers, output registers
// assumes: all link pins are asynchronous to i_clk, sclk period well above 4 i_clk periods
`timescale 1ns/100ps
`include "qdsu_regs.svh"
module qdsu_device
  import qdsu_pkg::*;
#(
  parameter int FRAME_BITS = `QDSU_FRAME_BITS,
  parameter int CHANNELS   = 4
)
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // straps
  input  wire logic [1:0]  i_addr_sel,
  input  wire logic        i_reset_level_select,
  // link
  qdsu_link_if.dev_mp      link,
  // converter outputs, channel A in the low slice
  output logic [63:0]      o_out_code,
  output logic [7:0]       o_out_pd_mode,
  output logic             o_frame_done
);

  // ports and shifter are sized for one frame length and four channels only
  initial begin
    if (FRAME_BITS != 24 || CHANNELS != 4) begin
      $error("qdsu_device: only 24-bit frames and four channels are built");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers; stage one is read only by stage two
  // sdata rides the same stages as sclk, so each bit is seen with its edge
  // limitation: sclk must stay high and low for at least four i_clk periods
  logic [4:0] meta_r;
  logic [4:0] sync_r;
  logic [1:0] last_r;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_r <= 5'h01;
      sync_r <= 5'h01;
      last_r <= 2'h0;
    end else begin
      meta_r <= {link.port_disable, link.update_strobe, link.sdata, link.sclk, link.sync_n};
      sync_r <= meta_r;
      last_r <= {sync_r[3], sync_r[1]};
    end
  end

  wire logic frame_n   = sync_r[0];
  wire logic sclk_fall = last_r[0] & ~sync_r[1];
  wire logic strobe_up = ~last_r[1] & sync_r[3];
  wire logic listening = ~sync_r[4];

  ////////////////////////////////////////////////////////////////////////////
  // shift register, msb first, sampled on the falling sclk edge
  logic [23:0] shift_r;
  logic [4:0]  count_r;
  logic        active_r;
  wire logic   take_bit = active_r & ~frame_n & sclk_fall & listening;
  // dropping active on port disable keeps a half-seen frame from landing
  wire logic   last_bit = take_bit & (count_r == 5'(FRAME_BITS - 1));
  wire logic [23:0] frame = {shift_r[22:0], sync_r[2]};

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      shift_r  <= 24'h000000;
      count_r  <= 5'h00;
      active_r <= 1'b0;
    end else if (frame_n | ~listening) begin
      // frame select high clears partial frame
      shift_r  <= 24'h000000;
      count_r  <= 5'h00;
      active_r <= listening;
    end else if (last_bit) begin
      active_r <= 1'b0;
      count_r  <= 5'h00;
    end else if (take_bit) begin
      shift_r <= frame;
      count_r <= count_r + 5'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame decode
  wire logic       addr_ok  = ({frame[`QDSU_ADDR_HI_POS], frame[`QDSU_ADDR_LO_POS]} == i_addr_sel);
  wire logic       do_frame = last_bit & addr_ok;
  wire logic       ld_all   = frame[`QDSU_LOAD_ALL_POS];
  wire logic       ld_sel   = frame[`QDSU_LOAD_SEL_POS];
  wire logic [1:0] chan     = {frame[`QDSU_CHAN_HI_POS], frame[`QDSU_CHAN_LO_POS]};
  wire logic       pd_flag  = frame[`QDSU_PD_FLAG_POS];
  // pd flag: bits 15:14 become the state, bit 13 ignored, 00 read as high-z
  wire logic [1:0] pd_bits  = {frame[`QDSU_PD_MODE_HI_POS], frame[`QDSU_PD_MODE_LO_POS]};
  qdsu_chan_type   new_word;
  assign new_word.pd_mode = pd_flag ? ((pd_bits == 2'h0) ? `QDSU_PD_HIZ : pd_bits)
                                    : `QDSU_PD_NONE;
  assign new_word.code    = frame[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // holding buffers and output registers
  qdsu_chan_type hold_r [4];
  qdsu_chan_type out_r  [4];
  logic          pending_rst_r;
  wire qdsu_chan_type reset_word = '{pd_mode: `QDSU_PD_NONE,
    code: i_reset_level_select ? `QDSU_MID_SCALE : `QDSU_ZERO_SCALE};

  function automatic logic [3:0] chan_onehot(input logic [1:0] sel);
    chan_onehot = 4'h1 << sel;
  endfunction

  wire logic [3:0] chan_hit  = chan_onehot(chan);
  wire logic [3:0] write_buf = do_frame ? chan_hit : 4'h0;
  wire logic [3:0] load_new  = (do_frame & (ld_all | ld_sel)) ? chan_hit : 4'h0;
  // a frame load wins over a strobe arriving in the same cycle
  wire logic [3:0] load_held = (do_frame & ld_all) ? ~chan_hit
                             : (strobe_up ? 4'hF : 4'h0);

  // strap read once, on the first edge after reset release
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pending_rst_r <= 1'b1;
    end else begin
      pending_rst_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_frame_done <= 1'b0;
    end else begin
      o_frame_done <= do_frame;
    end
  end

  // holding buffers
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        hold_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (pending_rst_r) begin
          hold_r[i] <= reset_word;
        end else if (write_buf[i]) begin
          hold_r[i] <= new_word;
        end
      end
    end
  end

  // output registers; a buffer left alone reloads its own value on strobe
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        out_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (pending_rst_r) begin
          out_r[i] <= reset_word;
        end else if (load_new[i]) begin
          out_r[i] <= new_word;
        end else if (load_held[i]) begin
          out_r[i] <= hold_r[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs from flops
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_out_code    <= 64'h0000000000000000;
      o_out_pd_mode <= 8'h00;
    end else begin
      for (int i = 0; i < 4; i++) begin
        o_out_code[16*i +: 16]  <= out_r[i].code;
        o_out_pd_mode[2*i +: 2] <= out_r[i].pd_mode;
      end
    end
  end

endmodule

// File: qdsu_host.sv
// qdsu_host.sv: host end; shifts one 24-bit frame per request, msb first
// assumes: i_frame is sampled once, in the cycle i_send is taken from IDLE; sclk derived by divider
`timescale 1ns/100ps
`include "qdsu_regs.svh"
module qdsu_host
  import qdsu_pkg::*;
#(
  parameter int HALF_DIV = `QDSU_SCLK_HALF_DIV
)
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // user side
  input  wire logic        i_send,
  input  wire logic [23:0] i_frame,
  input  wire logic        i_strobe,
  input  wire logic        i_port_disable,
  output logic             o_busy,
  output logic             o_done,
  // link
  qdsu_link_if.host_mp     link
);

  initial begin
    if (HALF_DIV < 2 || HALF_DIV > 255) $error("qdsu_host: HALF_DIV out of range");
  end

  typedef enum logic [1:0] {IDLE, LEAD, SHIFT, TAIL} qdsu_hstate_type;
  qdsu_hstate_type state_r;
  logic [7:0]  div_r;
  logic [4:0]  bits_r;
  logic [23:0] sh_r;
  logic        sclk_r, sync_n_r, sdata_r, strobe_r, dis_r;
  wire logic   tick = (div_r == 8'(HALF_DIV - 1));

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer; data changes on rising sclk, valid at falling
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r  <= IDLE;
      div_r    <= 8'h00;
      bits_r   <= 5'h00;
      sh_r     <= 24'h000000;
      sclk_r   <= 1'b0;
      sync_n_r <= 1'b1;
      sdata_r  <= 1'b0;
      o_busy   <= 1'b0;
      o_done   <= 1'b0;
    end else begin
      o_done <= 1'b0;
      div_r  <= (state_r == IDLE || tick) ? 8'h00 : div_r + 8'h01;
      case (state_r)
        IDLE: begin
          if (i_send) begin
            sh_r     <= i_frame;
            sync_n_r <= 1'b0;
            o_busy   <= 1'b1;
            state_r  <= LEAD;
          end
        end
        LEAD: begin
          if (tick) begin
            sclk_r  <= 1'b1;
            sdata_r <= sh_r[23];
            sh_r    <= {sh_r[22:0], 1'b0};
            bits_r  <= 5'h00;
            state_r <= SHIFT;
          end
        end
        SHIFT: begin
          if (tick) begin
            sclk_r <= ~sclk_r;
            if (sclk_r) begin
              // falling edge; frame stays low for all 24
              if (bits_r == 5'd23) begin
                state_r <= TAIL;
              end
              bits_r <= bits_r + 5'h01;
            end else begin
              sdata_r <= sh_r[23];
              sh_r    <= {sh_r[22:0], 1'b0};
            end
          end
        end
        TAIL: begin
          if (tick) begin
            sync_n_r <= 1'b1;
            o_busy   <= 1'b0;
            o_done   <= 1'b1;
            state_r  <= IDLE;
          end
        end
        default: state_r <= IDLE;
      endcase
    end
  end

  // strobe and port disable are registered levels; hold low for serial-only use
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      strobe_r <= 1'b0;
      dis_r    <= 1'b0;
    end else begin
      strobe_r <= i_strobe & ~o_busy;
      dis_r    <= i_port_disable;
    end
  end

  assign link.sync_n        = sync_n_r;
  assign link.sclk          = sclk_r;
  assign link.sdata         = sdata_r;
  assign link.update_strobe = strobe_r;
  assign link.port_disable  = dis_r;

endmodule

// File: qdsu_link_assertions.sv
// qdsu_link_assertions.sv: timing checks on the host-to-device link
// assumes: host built with HALF_DIV 4, link sampled by i_clk
`timescale 1ns/100ps
module qdsu_link_assertions (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic update_strobe,
  input wire logic port_disable
);
  // falling sclk edges seen in the current frame
  logic       sclk_q_r;
  logic [5:0] falls_r;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sclk_q_r <= 1'b0;
      falls_r  <= 6'h00;
    end else begin
      sclk_q_r <= sclk;
      falls_r  <= sync_n ? 6'h00 : falls_r + {5'h00, sclk_q_r & ~sclk};
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  a_idle_sclk_low: assert property (sync_n |-> !sclk)
    else $error("sclk moved outside a frame");
  a_strobe_quiet_frame: assert property (!sync_n |-> !update_strobe)
    else $error("strobe high inside a frame");
  a_sclk_after_select: assert property ($fell(sync_n) |-> ##[1:6] sclk)
    else $error("no sclk after frame start");
  a_data_stable_fall: assert property ($fell(sclk) |-> $stable(sdata))
    else $error("data moved at falling sclk");
  a_sclk_high_width: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("sclk high time wrong");
  a_frame_edge_count: assert property ($rose(sync_n) |-> falls_r == 6'h18)
    else $error("frame did not carry 24 edges");
  a_select_min_low: assert property ($fell(sync_n) |-> !sync_n [*8])
    else $error("frame select rose early");
  a_frame_bounded: assert property ($fell(sync_n) |-> ##[150:260] $rose(sync_n))
    else $error("frame length out of bounds");
  // port disable high mid-frame is one way to see an ignored frame; a frame for another address is also ignored
  c_frame_end: cover property ($rose(sync_n));
  c_strobe: cover property ($rose(update_strobe));
  c_disabled: cover property (port_disable && !sync_n);
endmodule

// File: tb_quad_dac_serial_update.sv
// tb_quad_dac_serial_update.sv: host and device joined, model compared at every result
// assumes: second device on lk2 is driven by the bench, once with a frame cut short at 12 bits and once with a full 24-bit frame
`timescale 1ns/100ps
module tb_quad_dac_serial_update;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_send = 1'b0;
  logic [23:0] i_frame = 24'h000000;
  logic        i_strobe = 1'b0;
  logic        i_port_disable = 1'b0;
  logic [1:0]  addr = 2'h0;
  logic        rsel = 1'b0;
  logic        busy, done, done_a, done_b;
  logic [63:0] code_a, code_b;
  logic [7:0]  pd_a, pd_b;
  logic [23:0] cap, f;
  logic [17:0] hb [4];
  logic [17:0] ob [4];
  integer      fails = 0;
  integer      comparisons = 0;
  integer      seed = 23;
  integer      n_done_a = 0;
  integer      n_done_b = 0;
  always #25 i_clk = ~i_clk;
  qdsu_link_if lk ();
  qdsu_link_if lk2 ();
  qdsu_host #(.HALF_DIV(4)) u_qdsu_host (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_send(i_send),
    .i_frame(i_frame), .i_strobe(i_strobe), .i_port_disable(i_port_disable), .o_busy(busy),
    .o_done(done), .link(lk.host_mp));
  qdsu_device u_qdsu_device (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr_sel(addr),
    .i_reset_level_select(rsel), .link(lk.dev_mp), .o_out_code(code_a), .o_out_pd_mode(pd_a),
    .o_frame_done(done_a));
  qdsu_device u_qdsu_device_2 (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr_sel(addr),
    .i_reset_level_select(rsel), .link(lk2.dev_mp), .o_out_code(code_b), .o_out_pd_mode(pd_b),
    .o_frame_done(done_b));
  qdsu_link_assertions u_qdsu_link_assertions (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .sync_n(lk.sync_n), .sclk(lk.sclk), .sdata(lk.sdata), .update_strobe(lk.update_strobe),
    .port_disable(lk.port_disable));
  always @(negedge lk.sclk) if (!lk.sync_n) cap = {cap[22:0], lk.sdata};
  always @(negedge i_clk) begin
    if (done_a === 1'b1) n_done_a++;
    if (done_b === 1'b1) n_done_b++;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp_all(input logic [63:0] c, input logic [7:0] p);
    for (int i = 0; i < 4; i++) begin
      check("mode", {22'h0, p[2*i+:2]}, {22'h0, ob[i][17:16]});
      // code is meaningless while powered down, so it is skipped then
      if (ob[i][17:16] == 2'h0) check("code", {8'h0, c[16*i+:16]}, {6'h0, ob[i]});
    end
  endtask
  task automatic model(input logic [23:0] w);
    logic [17:0] v;
    v = w[16] ? {((w[15:14] == 2'h0) ? 2'h3 : w[15:14]), 16'h0000} : {2'h0, w[15:0]};
    if (w[23:22] != addr || i_port_disable) return;
    hb[w[18:17]] = v;
    if (w[21]) ob = hb;
    else if (w[20]) ob[w[18:17]] = v;
  endtask
  task automatic send(input logic [23:0] w);
    int t;
    int n0;
    n0 = n_done_a;
    i_frame = w;
    i_send = 1'b1;
    @(negedge i_clk);
    i_send = 1'b0;
    check("busy", {23'h0, busy}, 24'h000001);
    for (t = 0; t < 400 && done !== 1'b1; t++) @(negedge i_clk);
    if (t == 400) begin
      fails++;
      report_and_stop();
    end
    check("wire", cap, w);
    repeat (10) @(negedge i_clk);
    check("frame done", 24'(n_done_a - n0), {23'h0, (w[23:22] == addr) && !i_port_disable});
    model(w);
  endtask
  task automatic bang(input logic [23:0] w, input int n);
    int n0;
    n0 = n_done_b;
    lk2.sync_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (4) @(negedge i_clk);
      lk2.sdata = w[23-i];
      lk2.sclk = 1'b1;
      repeat (4) @(negedge i_clk);
      lk2.sclk = 1'b0;
    end
    repeat (4) @(negedge i_clk);
    lk2.sync_n = 1'b1;
    lk2.sdata = ~lk2.sdata;
    repeat (10) @(negedge i_clk);
    check("frame done b", 24'(n_done_b - n0), {23'h0, n == 24});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {lk2.sync_n, lk2.sclk, lk2.sdata, lk2.port_disable} = 4'h8;
    lk2.update_strobe = 1'b0;
    for (int r = 0; r < 2; r++) begin
      rsel = r[0];
      addr = r ? 2'h2 : 2'h0;
      i_sys_rst = 1'b1;
      repeat (20) @(negedge i_clk);
      i_sys_rst = 1'b0;
      for (int i = 0; i < 4; i++) ob[i] = r ? 18'h08000 : 18'h00000;
      hb = ob;
      repeat (4) @(negedge i_clk);
      cmp_all(code_a, pd_a);
      f = {addr, 6'h12, 16'hA5C3};
      bang(f, 12);
      cmp_all(code_b, pd_b);
      bang(f, 24);
      model(f);
      cmp_all(code_b, pd_b);
      for (int i = 0; i < 4; i++) ob[i] = r ? 18'h08000 : 18'h00000;
      hb = ob;
      for (int k = 0; k < 16; k++) begin
        f = 24'($random(seed));
        if (k % 3 != 0) f[23:22] = addr;
        i_port_disable = (k == 5);
        repeat (2) @(negedge i_clk);
        send(f);
        cmp_all(code_a, pd_a);
        if (k % 4 == 3) begin
          i_strobe = 1'b1;
          repeat (3) @(negedge i_clk);
          i_strobe = 1'b0;
          repeat (10) @(negedge i_clk);
          ob = hb;
          cmp_all(code_a, pd_a);
        end
      end
    end
    report_and_stop();
  end
endmodule
